// [rtl/p5gw_map.svh]
`ifndef P5GW_MAP_SVH
`define P5GW_MAP_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define P5GW_OFF_MODE 16'hFFCC
`define P5GW_OFF_DATA 16'hFFD8
`define P5GW_OFF_PULL 16'hFFE2
`define P5GW_OFF_DIR 16'hFFE8

// ---------------------------------------------------------------
// Reset values and fixed read values
// ---------------------------------------------------------------
`define P5GW_RST_MODE 8'h00
`define P5GW_RST_DATA 8'h00
`define P5GW_RST_PULL 8'h00
`define P5GW_RST_DIR 8'h00
`define P5GW_DIR_READ 8'hFF
`define P5GW_UNMAPPED_READ 8'h00

`endif

// [rtl/p5gw_pkg.sv]
package p5gw_pkg;

    // ---------------------------------------------------------------
    // Operating modes of the chip
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        P5GW_ACTIVE = 3'b000,
        P5GW_SUBACTIVE = 3'b001,
        P5GW_SLEEP = 3'b010,
        P5GW_SUBSLEEP = 3'b011,
        P5GW_WATCH = 3'b100,
        P5GW_STANDBY = 3'b101
    } p5gw_opmode_t;

    // ---------------------------------------------------------------
    // Per-pin function
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        P5GW_FN_INPUT = 2'b00,
        P5GW_FN_OUTPUT = 2'b01,
        P5GW_FN_WAKE = 2'b10
    } p5gw_pinfn_t;

endpackage : p5gw_pkg

// [rtl/p5gw_port.sv]
`include "p5gw_map.svh"

module p5gw_port (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Operating mode of the chip
    input wire logic [2:0] op_mode,
    // Port pins
    input wire logic [7:0] port_pin_in,
    output logic [7:0] port_pin_out,
    output logic [7:0] port_pin_oe,
    output logic [7:0] pullup_on,
    // Wakeup requests, active low like the pins
    output logic [7:0] wakeup_input_pin
);

    logic [7:0] port_data_latch;
    logic [7:0] direction_control;
    logic [7:0] pullup_control;
    logic [7:0] pin_mode_select;
    logic [7:0] next_pin_out;
    logic [7:0] next_pin_oe;
    logic [7:0] next_pullup;
    logic [7:0] next_rdata;
    logic hold_state;
    logic standby;

    // ---------------------------------------------------------------
    // Per-pin function decode
    // ---------------------------------------------------------------
    function automatic p5gw_pkg::p5gw_pinfn_t pin_fn(input logic wake_select_bit,
                                                     input logic dir);
        if (wake_select_bit) begin
            return p5gw_pkg::P5GW_FN_WAKE;
        end else if (dir) begin
            return p5gw_pkg::P5GW_FN_OUTPUT;
        end else begin
            return p5gw_pkg::P5GW_FN_INPUT;
        end
    endfunction : pin_fn

    function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
        return addr == off;
    endfunction : hit

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            port_data_latch <= `P5GW_RST_DATA;
        end else if (ce && reg_wr && hit(reg_addr, `P5GW_OFF_DATA)) begin
            port_data_latch <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            direction_control <= `P5GW_RST_DIR;
        end else if (ce && reg_wr && hit(reg_addr, `P5GW_OFF_DIR)) begin
            direction_control <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pullup_control <= `P5GW_RST_PULL;
        end else if (ce && reg_wr && hit(reg_addr, `P5GW_OFF_PULL)) begin
            pullup_control <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pin_mode_select <= `P5GW_RST_MODE;
        end else if (ce && reg_wr && hit(reg_addr, `P5GW_OFF_MODE)) begin
            pin_mode_select <= reg_wdata;
        end
    end

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    always_comb begin
        next_rdata = `P5GW_UNMAPPED_READ;
        if (hit(reg_addr, `P5GW_OFF_DATA)) begin
            // Output bits show the latch, input bits the pin.
            next_rdata = (direction_control & port_data_latch)
                       | (~direction_control & port_pin_in);
        end else if (hit(reg_addr, `P5GW_OFF_DIR)) begin
            next_rdata = `P5GW_DIR_READ;
        end else if (hit(reg_addr, `P5GW_OFF_PULL)) begin
            next_rdata = pullup_control;
        end else if (hit(reg_addr, `P5GW_OFF_MODE)) begin
            next_rdata = pin_mode_select;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // Pin drive per operating mode
    // ---------------------------------------------------------------
    always_comb begin
        hold_state = 1'b0;
        standby = 1'b0;
        case (p5gw_pkg::p5gw_opmode_t'(op_mode))
            p5gw_pkg::P5GW_SLEEP: hold_state = 1'b1;
            p5gw_pkg::P5GW_SUBSLEEP: hold_state = 1'b1;
            p5gw_pkg::P5GW_WATCH: hold_state = 1'b1;
            p5gw_pkg::P5GW_STANDBY: standby = 1'b1;
            default: hold_state = 1'b0;
        endcase
    end

    generate
        for (genvar i = 0; i < 8; i++) begin : g_pin
            p5gw_pkg::p5gw_pinfn_t fn;
            assign fn = pin_fn(pin_mode_select[i], direction_control[i]);
            always_comb begin
                next_pin_out[i] = port_data_latch[i];
                next_pin_oe[i] = (fn == p5gw_pkg::P5GW_FN_OUTPUT);
                // The pull-up acts on a GPIO input only.
                next_pullup[i] = (fn == p5gw_pkg::P5GW_FN_INPUT) && pullup_control[i];
                if (standby) begin
                    next_pin_oe[i] = 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            port_pin_oe <= 8'h00;
            port_pin_out <= 8'h00;
            pullup_on <= 8'h00;
        end else if (ce && !hold_state) begin
            port_pin_oe <= next_pin_oe;
            port_pin_out <= next_pin_out;
            pullup_on <= next_pullup;
        end
    end

    // Pins not in wake mode report an idle (high) request.
    always_ff @(posedge clk) begin
        if (srst) begin
            wakeup_input_pin <= 8'hFF;
        end else if (ce) begin
            wakeup_input_pin <= port_pin_in | ~pin_mode_select;
        end
    end

endmodule : p5gw_port

// [tb/p5gw_board.sv]
module p5gw_board (
    // Port drive
    input wire logic [7:0] oe,
    input wire logic [7:0] out,
    input wire logic [7:0] pu,
    // Board drive
    input wire logic [7:0] ext,
    // Pin level
    output logic [7:0] lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    // Undriven pins show the pull-up, else whatever the board puts there.
    assign lvl = (oe & out) | (~oe & (pu | ext));
endmodule : p5gw_board

// [tb/p5gw_monitor.sv]
module p5gw_monitor (
    // Clock, reset
    input wire logic clk,
    input wire logic srst,
    // Registers
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins
    input wire logic [2:0] op_mode,
    input wire logic [7:0] port_pin_in,
    input wire logic [7:0] port_pin_out,
    input wire logic [7:0] port_pin_oe,
    input wire logic [7:0] pullup_on,
    input wire logic [7:0] wakeup_input_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_dir_ones: assert property (reg_rd && reg_addr == 16'hFFE8 |=> reg_rdata == 8'hFF)
        else $error("dir read");
    a_rst_quiet: assert property ($past(srst) |-> !port_pin_oe && !pullup_on)
        else $error("reset pins");
    a_pull_excl: assert property ((pullup_on & port_pin_oe) == 8'h00)
        else $error("pull on output");
    a_standby_hiz: assert property (op_mode == 3'd5 |=> port_pin_oe == 8'h00)
        else $error("standby drive");
    a_hold_frozen: assert property (op_mode inside {3'd2, 3'd3, 3'd4} |=>
        $stable(port_pin_oe) && $stable(port_pin_out) && $stable(pullup_on))
        else $error("hold moved");
    a_out_latch: assert property (reg_wr && reg_addr == 16'hFFD8 ##1 op_mode < 3'd2 |=>
        port_pin_out == $past(reg_wdata, 2)) else $error("latch out");
    a_wake_nodrive: assert property (reg_wr && reg_addr == 16'hFFCC ##1 op_mode < 3'd2 |=>
        (port_pin_oe & $past(reg_wdata, 2)) == 8'h00) else $error("wake driven");
    a_wake_follow: assert property (reg_wr && reg_addr == 16'hFFCC ##1 op_mode < 3'd2
        && !(reg_wr && reg_addr == 16'hFFCC) |=>
        wakeup_input_pin == ($past(port_pin_in) | ~$past(reg_wdata, 2))) else $error("wake");
    c_wake: cover property (wakeup_input_pin != 8'hFF);
    c_standby: cover property (op_mode == 3'd5 ##1 pullup_on != 8'h00);
    c_dir_read: cover property (reg_rd && reg_addr == 16'hFFE8);
endmodule : p5gw_monitor
bind p5gw_port p5gw_monitor i_p5gw_monitor (.*);

// [tb/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0;
    logic [15:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, ext = 0, lvl, reg_rdata, pout, poe, pu, wk;
    logic [2:0] op_mode = 0;
    logic [7:0] m[4] = '{default: 8'h00};
    localparam logic [15:0] AD[4] = '{16'hFFCC, 16'hFFD8, 16'hFFE2, 16'hFFE8};
    integer seed = 56, fails = 0, total_checks = 0, cyc = 0, i;
    initial forever #20 clk = ~clk;
    p5gw_port i_p5gw_port (.clk, .srst, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .op_mode, .port_pin_in(lvl), .port_pin_out(pout), .port_pin_oe(poe),
        .pullup_on(pu), .wakeup_input_pin(wk));
    p5gw_board i_p5gw_board (.oe(poe), .out(pout), .pu, .ext, .lvl);
    function automatic logic [7:0] pull_x();
        return ~m[3] & ~m[0] & m[2];
    endfunction : pull_x
    task chk(string n, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task wr(int k, logic [7:0] d);
        @(posedge clk);
        reg_addr <= AD[k];
        reg_wdata <= d;
        reg_wr <= 1'b1;
        m[k] = d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(logic [15:0] a, logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("rdata", e, reg_rdata);
    endtask : rd
    task final_report;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            final_report;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd(16'hFFCC, 8'h00);
        rd(16'hFFE2, 8'h00);
        rd(16'hFFE8, 8'hFF);
        rd(16'hFFD0, 8'h00);
        chk("out", 8'h00, pout);
        chk("oe", 8'h00, poe);
        for (i = 0; i < 80; i++) begin
            ext <= 8'($random(seed));
            wr(i % 4, (i % 16 == 3) ? 8'h00 : 8'($random(seed)));
            rd(16'hFFD8, (m[3] & m[1]) | (~m[3] & (pull_x() | ext)));
            chk("oe", m[3] & ~m[0], poe);
            chk("pull", pull_x(), pu);
            chk("out", m[1], pout);
            chk("wake", ~m[0] | ext, wk);
        end
        op_mode <= 3'd5;
        repeat (2) @(posedge clk);
        #1 chk("sb oe", 8'h00, poe);
        chk("sb pull", pull_x(), pu);
        op_mode <= 3'd2;
        wr(0, 8'h00);
        wr(3, 8'hFF);
        #1 chk("hold oe", 8'h00, poe);
        op_mode <= 3'd1;
        repeat (2) @(posedge clk);
        #1 chk("sub oe", 8'hFF, poe);
        final_report;
    end
endmodule : tb
